// [rtl/oag_pkg.sv]
// shared constants and types of the operand address generator
package oag_pkg;

  // ---------------------------------------------------------------
  // data widths
  // ---------------------------------------------------------------
  localparam int unsigned OAG_WORD_W = 16;
  localparam int unsigned OAG_REGS = 16;

  // ---------------------------------------------------------------
  // apb register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OAG_ADDR_CTRL = 8'h00;
  localparam logic [7:0] OAG_ADDR_INSTR0 = 8'h04;
  localparam logic [7:0] OAG_ADDR_INSTR1 = 8'h08;
  localparam logic [7:0] OAG_ADDR_PROG = 8'h0c;
  localparam logic [7:0] OAG_ADDR_REGSEL = 8'h10;
  localparam logic [7:0] OAG_ADDR_REGDATA = 8'h14;
  localparam logic [7:0] OAG_ADDR_STATUS = 8'h18;
  localparam logic [7:0] OAG_ADDR_TARGET = 8'h1c;
  localparam logic [7:0] OAG_ADDR_OPERAND = 8'h20;
  localparam logic [7:0] OAG_ADDR_WDATA = 8'h24;
  localparam logic [7:0] OAG_ADDR_FPIN = 8'h28;
  localparam logic [7:0] OAG_ADDR_FPOUT = 8'h2c;
  localparam logic [7:0] OAG_ADDR_FPNEG = 8'h30;
  localparam logic [7:0] OAG_ADDR_PAIR = 8'h34;
  localparam logic [7:0] OAG_ADDR_FPSCALE = 8'h38;
  localparam logic [7:0] OAG_ADDR_BITMASK = 8'h3c;

  // ---------------------------------------------------------------
  // control and status fields (lsb numbering of the apb word)
  // ---------------------------------------------------------------
  localparam int unsigned OAG_CTRL_START = 0;
  localparam int unsigned OAG_CTRL_MODE_LSB = 1;
  localparam int unsigned OAG_CTRL_BRANCH = 4;
  localparam int unsigned OAG_CTRL_WRITE = 5;
  localparam int unsigned OAG_STAT_BUSY = 0;
  localparam int unsigned OAG_STAT_DONE = 1;
  localparam int unsigned OAG_STAT_OCTET = 2;
  localparam int unsigned OAG_STAT_NEG = 3;
  localparam int unsigned OAG_STAT_PTR = 4;

  // ---------------------------------------------------------------
  // instruction fields, numbered with bit 0 as the msb
  // ---------------------------------------------------------------
  localparam int unsigned OAG_PRIM_FIRST = 8;
  localparam int unsigned OAG_NIB_FIRST = 12;
  localparam int unsigned OAG_IDX_FIRST = 12;
  localparam int unsigned OAG_IND_BIT = 15;

  // ---------------------------------------------------------------
  // formats and reset values
  // ---------------------------------------------------------------
  localparam logic [11:0] OAG_FP_EXP_UNITY = 12'h400;
  localparam int unsigned OAG_FP_FRAC_W = 22;
  localparam logic [15:0] OAG_RST_WORD = 16'h0000;
  localparam logic [3:0] OAG_RST_SEL = 4'h0;
  localparam logic [15:0] OAG_BIT0_MASK = 16'h8000;

  typedef enum logic [2:0] {
    OAG_MODE_MEMREF = 3'h0,
    OAG_MODE_IMM = 3'h1,
    OAG_MODE_SDISP = 3'h2,
    OAG_MODE_SIDX = 3'h3,
    OAG_MODE_BYTE = 3'h4,
    OAG_MODE_BIT = 3'h5
  } oag_mode_t;

  typedef enum logic [3:0] {
    OAG_ST_IDLE = 4'b0001,
    OAG_ST_CALC = 4'b0010,
    OAG_ST_PTR = 4'b0100,
    OAG_ST_OPER = 4'b1000
  } oag_state_t;

endpackage

// [rtl/oag_top.sv]
// operand address generator: field decode, effective address and data formats
// Operation
// - sixteen-bit words, bit 0 is the most significant bit
// - doubleword from even register (upper) and next odd register (lower)
// - two bytes per word; select 0 is bits 0-7, 1 is bits 8-15
// - fixed point: msb sign, zero positive, negatives in two's complement
// - float: sign bit 0, exponent bits 1-9, 400 hex means scale one
// - zero fraction forces exponent to zero, giving an all-zero value
// - negative float is integer two's complement of its magnitude
// - sixteen registers: 0 is panel switches, 1-15 general flip-flops
// - each register designator is a four-bit field, except the three-bit index field
// - only registers 1-7 index; index field zero means no indexing
// - sixteen-bit word address sent to memory with read or write
// - no index, no indirect: second word is the address
// - indexed: signed index register plus second word, low 16 bits
// - indirect: address fetched from second word location, one extra cycle
// - indexed indirect: index added first, then address fetched from sum
// - immediate: operand is the second word, program register advances two
// - short displaced: nibble displacement added to base pointer, unmodified
// - branch in short displaced mode uses program register as base
// - short indexed: named register contents are the address
// - byte: base plus displacement shifted right, shifted bit selects byte
// - bit number 0-15, zero selects the most significant bit
module oag_top
  import oag_pkg::*;
#(
  parameter int unsigned ADDR_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] panel_switches,
  output logic [15:0] mem_addr,
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack
);

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  if (ADDR_W != OAG_WORD_W) begin : g_bad_width
    $error("oag_top serves only a 16-bit word address");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // fields are counted from the msb, so bit n of a word sits at index 15-n
  function automatic logic [3:0] nib(input logic [15:0] w, input int unsigned first);
    nib = w[15 - first -: 4];
  endfunction

  // the carry out is dropped on purpose: addresses wrap round memory
  function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    add16 = s[15:0];
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [15:0] gpr [1:OAG_REGS-1];
  logic [15:0] sw_meta;
  logic [15:0] sw_sync;
  logic [15:0] instr0;
  logic [15:0] instr1;
  logic [15:0] prog;
  logic [3:0] reg_sel;
  logic [15:0] wdata;
  logic [31:0] fp_in;
  oag_mode_t mode;
  logic branch;
  logic write_op;
  oag_state_t state;
  logic done;
  logic ptr_used;
  logic octet_select;
  logic [15:0] word_target;
  logic [15:0] operand;

  logic wr_en;
  logic rd_en;
  logic start;
  logic [15:0] next_word_target;
  logic next_octet;
  logic [15:0] pair_hi;
  logic [15:0] pair_lo;
  logic [31:0] fp_abs;
  logic [31:0] fp_norm;
  logic [8:0] fp_scale;
  logic [15:0] bit_mask;

  // ---------------------------------------------------------------
  // register file read
  // ---------------------------------------------------------------
  function automatic logic [15:0] rd_reg(input logic [3:0] idx);
    if (idx == 4'h0) begin
      rd_reg = sw_sync;
    end else begin
      rd_reg = gpr[idx];
    end
  endfunction

  // panel switches are operator set and asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_meta <= OAG_RST_WORD;
      sw_sync <= OAG_RST_WORD;
    end else begin
      sw_meta <= panel_switches;
      sw_sync <= sw_meta;
    end
  end

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign start = wr_en && (paddr == OAG_ADDR_CTRL) && pwdata[OAG_CTRL_START]
    && (state == OAG_ST_IDLE);

  // the map is dense: every aligned offset up to the bit mask is a register
  assign pslverr = psel && penable
    && (paddr[1:0] != 2'b00 || paddr > OAG_ADDR_BITMASK);

  // software set-up registers; the engine owns the program register and
  // the second word while it runs, so those writes are ignored when busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr0 <= OAG_RST_WORD;
      reg_sel <= OAG_RST_SEL;
      wdata <= OAG_RST_WORD;
      fp_in <= {OAG_RST_WORD, OAG_RST_WORD};
      mode <= OAG_MODE_MEMREF;
      branch <= 1'b0;
      write_op <= 1'b0;
    end else if (wr_en && state == OAG_ST_IDLE) begin
      case (paddr)
        OAG_ADDR_CTRL: begin
          mode <= oag_mode_t'(pwdata[OAG_CTRL_MODE_LSB +: 3]);
          branch <= pwdata[OAG_CTRL_BRANCH];
          write_op <= pwdata[OAG_CTRL_WRITE];
        end
        OAG_ADDR_INSTR0: instr0 <= pwdata[15:0];
        OAG_ADDR_REGSEL: reg_sel <= pwdata[3:0];
        OAG_ADDR_WDATA: wdata <= pwdata[15:0];
        OAG_ADDR_FPIN: fp_in <= pwdata;
        default: begin
        end
      endcase
    end
  end

  // general registers; a write to register 0 is dropped, the switches
  // cannot be loaded by program
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 1; i < OAG_REGS; i++) begin
        gpr[i] <= OAG_RST_WORD;
      end
    end else if (wr_en && state == OAG_ST_IDLE && paddr == OAG_ADDR_REGDATA
        && reg_sel != 4'h0) begin
      gpr[reg_sel] <= pwdata[15:0];
    end
  end

  // ---------------------------------------------------------------
  // data formats
  // ---------------------------------------------------------------
  // an odd designator is forced even; a process so that file writes are seen
  always_comb begin
    pair_hi = rd_reg({reg_sel[3:1], 1'b0});
    pair_lo = rd_reg({reg_sel[3:1], 1'b1});
  end

  assign fp_abs = fp_in[31] ? 32'h0 - fp_in : fp_in;

  always_comb begin
    fp_norm = fp_in;
    if (fp_abs[OAG_FP_FRAC_W-1:0] == {OAG_FP_FRAC_W{1'b0}}) begin
      fp_norm = 32'h0000_0000;
    end
  end

  // exponent sits in bits 1-9; the unity code is given with sign and two
  // fraction bits around it, hence the slice
  assign fp_scale = fp_abs[30:22] - OAG_FP_EXP_UNITY[10:2];

  assign bit_mask = OAG_BIT0_MASK >> nib(instr0, OAG_PRIM_FIRST);

  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      case (paddr)
        OAG_ADDR_CTRL: begin
          prdata = {26'h0, write_op, branch, mode, 1'b0};
        end
        OAG_ADDR_INSTR0: prdata = {16'h0, instr0};
        OAG_ADDR_INSTR1: prdata = {16'h0, instr1};
        OAG_ADDR_PROG: prdata = {16'h0, prog};
        OAG_ADDR_REGSEL: prdata = {28'h0, reg_sel};
        OAG_ADDR_REGDATA: prdata = {16'h0, rd_reg(reg_sel)};
        OAG_ADDR_STATUS: begin
          prdata = {27'h0, ptr_used, operand[15], octet_select, done,
            state != OAG_ST_IDLE};
        end
        OAG_ADDR_TARGET: prdata = {16'h0, word_target};
        OAG_ADDR_OPERAND: prdata = {16'h0, operand};
        OAG_ADDR_WDATA: prdata = {16'h0, wdata};
        OAG_ADDR_FPIN: prdata = fp_in;
        OAG_ADDR_FPOUT: prdata = fp_norm;
        OAG_ADDR_FPNEG: prdata = 32'h0 - fp_norm;
        OAG_ADDR_PAIR: prdata = {pair_hi, pair_lo};
        OAG_ADDR_FPSCALE: prdata = {{23{fp_scale[8]}}, fp_scale};
        OAG_ADDR_BITMASK: prdata = {16'h0, bit_mask};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // effective address
  // ---------------------------------------------------------------
  always_comb begin
    logic [3:0] idx;
    logic [15:0] base;
    logic [15:0] disp;
    idx = 4'h0;
    base = OAG_RST_WORD;
    disp = OAG_RST_WORD;
    next_word_target = instr1;
    next_octet = 1'b0;
    case (mode)
      OAG_MODE_MEMREF, OAG_MODE_BIT: begin
        idx = {1'b0, instr0[15 - OAG_IDX_FIRST -: 3]};
        if (idx == 4'h0) begin
          next_word_target = instr1;
        end else begin
          next_word_target = add16(instr1, gpr[idx]);
        end
      end
      OAG_MODE_SDISP: begin
        base = branch ? prog : gpr[1];
        next_word_target = add16(base, {12'h0, nib(instr0, OAG_NIB_FIRST)});
      end
      OAG_MODE_SIDX: begin
        next_word_target = rd_reg(nib(instr0, OAG_NIB_FIRST));
      end
      OAG_MODE_BYTE: begin
        idx = {nib(instr0, OAG_NIB_FIRST) & 4'he};
        base = rd_reg(idx);
        disp = rd_reg(idx | 4'h1);
        next_word_target = add16(base, {disp[15], disp[15:1]});
        next_octet = disp[0];
      end
      default: begin
        next_word_target = instr1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // each memory access holds mem_req until mem_ack; the pointer fetch is
  // the only extra cycle, indexing costs none
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= OAG_ST_IDLE;
      word_target <= OAG_RST_WORD;
      octet_select <= 1'b0;
      ptr_used <= 1'b0;
      mem_addr <= OAG_RST_WORD;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_wdata <= OAG_RST_WORD;
    end else begin
      case (state)
        OAG_ST_IDLE: begin
          if (start) begin
            state <= OAG_ST_CALC;
            ptr_used <= 1'b0;
          end
        end
        OAG_ST_CALC: begin
          word_target <= next_word_target;
          octet_select <= next_octet;
          if (mode == OAG_MODE_IMM) begin
            state <= OAG_ST_IDLE;
          end else if ((mode == OAG_MODE_MEMREF || mode == OAG_MODE_BIT)
              && instr0[15 - OAG_IND_BIT]) begin
            mem_addr <= next_word_target;
            mem_we <= 1'b0;
            mem_req <= 1'b1;
            ptr_used <= 1'b1;
            state <= OAG_ST_PTR;
          end else begin
            mem_addr <= next_word_target;
            mem_we <= write_op;
            mem_wdata <= wdata;
            mem_req <= 1'b1;
            state <= OAG_ST_OPER;
          end
        end
        OAG_ST_PTR: begin
          if (mem_ack) begin
            // single level: the fetched word is used as is
            word_target <= mem_rdata;
            mem_addr <= mem_rdata;
            mem_we <= write_op;
            mem_wdata <= wdata;
            state <= OAG_ST_OPER;
          end
        end
        OAG_ST_OPER: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            state <= OAG_ST_IDLE;
          end
        end
        default: begin
          state <= OAG_ST_IDLE;
          mem_req <= 1'b0;
        end
      endcase
    end
  end

  // operand capture; a byte read lands right-justified with zero fill
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operand <= OAG_RST_WORD;
    end else if (state == OAG_ST_CALC && mode == OAG_MODE_IMM) begin
      operand <= write_op ? wdata : instr1;
    end else if (state == OAG_ST_OPER && mem_ack && !mem_we) begin
      if (mode == OAG_MODE_BYTE) begin
        operand <= {8'h00, octet_select ? mem_rdata[7:0] : mem_rdata[15:8]};
      end else begin
        operand <= mem_rdata;
      end
    end
  end

  // second word and program register; immediate writes replace the
  // second word itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr1 <= OAG_RST_WORD;
      prog <= OAG_RST_WORD;
    end else if (state == OAG_ST_IDLE && wr_en && paddr == OAG_ADDR_INSTR1) begin
      instr1 <= pwdata[15:0];
    end else if (state == OAG_ST_IDLE && wr_en && paddr == OAG_ADDR_PROG) begin
      prog <= pwdata[15:0];
    end else if (state == OAG_ST_CALC) begin
      if (mode == OAG_MODE_IMM && write_op) begin
        instr1 <= wdata;
      end
      if (mode == OAG_MODE_IMM || mode == OAG_MODE_MEMREF || mode == OAG_MODE_BIT) begin
        prog <= add16(prog, 16'h0002);
      end else begin
        prog <= add16(prog, 16'h0001);
      end
    end
  end

  // done: hardware set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b0;
    end else if ((state == OAG_ST_OPER && mem_ack)
        || (state == OAG_ST_CALC && mode == OAG_MODE_IMM)) begin
      done <= 1'b1;
    end else if (start || (wr_en && paddr == OAG_ADDR_STATUS
        && pwdata[OAG_STAT_DONE])) begin
      done <= 1'b0;
    end
  end

endmodule

// [bench/oag_top_asserts.sv]
// port checker of the operand address generator
module oag_top_asserts
  import oag_pkg::*;
#(
  parameter int unsigned ADDR_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] panel_switches,
  input wire logic [15:0] mem_addr,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  logic acc;
  logic rd_acc;
  assign acc = psel && penable;
  assign rd_acc = acc && !pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  AST_RESET_QUIET: assert property ($rose(presetn) |->
    !mem_req && !mem_we && mem_addr == 16'h0000) else $error("memory port busy after reset");
  AST_REQ_HOLD: assert property (mem_req && !mem_ack |=> mem_req &&
    $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata)) else $error("request moved");
  AST_START_LAT: assert property (acc && pwrite && paddr == 8'h00 && pwdata[0] &&
    !mem_req |=> !mem_req) else $error("request before address was formed");
  AST_READY: assert property (psel |-> pready) else $error("wait state inserted");
  AST_UNMAPPED: assert property (acc && paddr > 8'h3c |-> pslverr)
    else $error("unmapped access not refused");
  AST_MAPPED: assert property (acc && paddr <= 8'h3c && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  AST_IDLE_RDATA: assert property (!rd_acc |-> prdata == 32'h00000000)
    else $error("read data outside read access");
  AST_UPPER_ZERO: assert property (rd_acc && (paddr <= 8'h24 || paddr == 8'h3c) |->
    prdata[31:16] == 16'h0000) else $error("word register upper half set");
  AST_BIT_ONEHOT: assert property (rd_acc && paddr == 8'h3c |-> $onehot(prdata[15:0]))
    else $error("bit mask not one hot");
  AST_FP_ZERO: assert property (rd_acc && paddr == 8'h2c && !prdata[31] &&
    prdata[21:0] == 22'h000000 |-> prdata == 32'h00000000) else $error("zero not all zero");
endmodule

bind oag_top oag_top_asserts #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .panel_switches(panel_switches), .mem_addr(mem_addr), .mem_req(mem_req), .mem_we(mem_we),
  .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

// [bench/oag_mem_model.sv]
// word memory answering the generator's requests after a settable delay
module oag_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] addr,
  input wire logic req,
  input wire logic we,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata,
  output logic ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] words [65536];
  logic [16:0] log_q [$];
  int lat = 0;
  int cnt;
  initial begin
    for (int i = 0; i < 65536; i++) begin
      words[i] = 16'(i * 7) ^ 16'h3c5a;
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      cnt <= 0;
      rdata <= 16'h0000;
    end else begin
      ack <= 1'b0;
      // released data bus never repeats the last word
      rdata <= ~rdata;
      if (req && !ack) begin
        if (cnt >= lat) begin
          ack <= 1'b1;
          cnt <= 0;
          log_q.push_back({we, addr});
          if (we) begin
            words[addr] <= wdata;
          end else begin
            rdata <= words[addr];
          end
        end else begin
          cnt <= cnt + 1;
        end
      end
    end
  end
endmodule

// [bench/test_operand_address_generator.sv]
// self-checking bench of the operand address generator
module test_operand_address_generator
  import oag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_req, mem_we, mem_ack;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv, fi, mg, fo;
  logic [3:0] pstrb;
  logic [15:0] panel_switches, mem_addr, mem_wdata, mem_rdata, prog;
  logic [15:0] rf [16];
  logic ev;
  logic [15:0] last_op = 16'h0000;
  int fails = 0;
  int total_checks = 0;
  oag_top #(.ADDR_W(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .panel_switches(panel_switches), .mem_addr(mem_addr),
    .mem_req(mem_req), .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));
  oag_mem_model mem_m (.clk(pclk), .rst_n(presetn), .addr(mem_addr), .req(mem_req),
    .we(mem_we), .wdata(mem_wdata), .rdata(mem_rdata), .ack(mem_ack));
  always #4 pclk = ~pclk;
  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) fails++;
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ---------------------------------------------------------------
  // one operation against the reference model
  // ---------------------------------------------------------------
  task automatic op(input logic [15:0] i0, i1, input int md, input logic br, we);
    logic [15:0] b, t, d, wd, x, pe;
    logic sel, ptr;
    logic [16:0] q [$];
    int nb;
    nb = i0[3:0];
    wd = $urandom;
    sel = 1'b0;
    pe = prog + ((md < 2 || md == 5) ? 16'h0002 : 16'h0001);
    b = (i0[3:1] != 3'h0) ? i1 + rf[i0[3:1]] : i1;
    t = b;
    ptr = (md == 0 || md == 5) && i0[0];
    if (ptr) begin
      t = mem_m.words[b];
      q.push_back({1'b0, b});
    end
    if (md == 2) t = (br ? prog : rf[1]) + 16'(nb);
    if (md == 3) t = rf[nb];
    if (md == 4) begin
      d = rf[nb | 1];
      t = rf[nb & 14] + {d[15], d[15:1]};
      sel = d[0];
    end
    if (md != 1) q.push_back({we, t});
    // a memory write leaves the operand register as it was
    x = we ? (md == 1 ? wd : last_op) : (md == 1 ? i1 : mem_m.words[t]);
    if (md == 4 && !we) x = sel ? {8'h00, x[7:0]} : {8'h00, x[15:8]};
    mem_m.lat = $urandom % 6;
    mem_m.log_q.delete();
    apb(1'b1, OAG_ADDR_INSTR0, {16'h0000, i0});
    apb(1'b1, OAG_ADDR_INSTR1, {16'h0000, i1});
    apb(1'b1, OAG_ADDR_WDATA, {16'h0000, wd});
    apb(1'b1, OAG_ADDR_CTRL, {26'h0, we, br, md[2:0], 1'b1});
    // a slow memory keeps the engine busy, so this write must be dropped
    if (md != 1 && mem_m.lat > 2) apb(1'b1, OAG_ADDR_INSTR0, {16'h0000, ~i0});
    for (int n = 0; n < 40; n++) begin
      apb(1'b0, OAG_ADDR_STATUS, 32'h0);
      if (rv[1] === 1'b1) break;
    end
    chk("done", 1'b1, rv[1]);
    chk("octet", sel, rv[2]);
    if (md != 4) chk("sign", x[15], rv[3]);
    chk("pointer", ptr, rv[4]);
    chk("accesses", q.size(), mem_m.log_q.size());
    foreach (q[i]) chk("access", q[i], mem_m.log_q[i]);
    if (md != 1) begin
      apb(1'b0, OAG_ADDR_TARGET, 32'h0);
      chk("target", t, rv);
    end
    apb(1'b0, OAG_ADDR_OPERAND, 32'h0);
    chk("operand", x, rv);
    apb(1'b0, OAG_ADDR_PROG, 32'h0);
    chk("prog", pe, rv);
    prog = pe;
    last_op = x;
    apb(1'b0, OAG_ADDR_INSTR0, 32'h0);
    chk("instr0", i0, rv);
    if (we && md != 1) chk("stored", wd, mem_m.words[t]);
    if (md == 1 && we) begin
      apb(1'b0, OAG_ADDR_INSTR1, 32'h0);
      chk("imm store", wd, rv);
    end
    if (md == 5) begin
      apb(1'b0, OAG_ADDR_BITMASK, 32'h0);
      chk("bitmask", 16'h8000 >> i0[7:4], rv);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    void'($urandom(35));
    panel_switches = $urandom;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rf[0] = panel_switches;
    for (int i = 1; i < 16; i++) rf[i] = $urandom;
    rf[1] = 16'hfffa;
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, OAG_ADDR_REGSEL, i);
      apb(1'b1, OAG_ADDR_REGDATA, {16'h0000, (i == 0) ? ~rf[0] : rf[i]});
    end
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, OAG_ADDR_REGSEL, i);
      apb(1'b0, OAG_ADDR_REGDATA, 32'h0);
      chk("regdata", rf[i], rv);
      apb(1'b0, OAG_ADDR_PAIR, 32'h0);
      chk("pair", {rf[i & 14], rf[i | 1]}, rv);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 1'b1, ev);
    $display("test registers done");
    prog = $urandom;
    apb(1'b1, OAG_ADDR_PROG, {16'h0000, prog});
    // every mode sees every nibble; register 0 is never a destination here
    for (int k = 0; k < 96; k++) begin
      op(($urandom & 16'hfff0) | 16'((k / 6) % 16), $urandom, k % 6, $urandom, $urandom);
    end
    $display("test addressing done");
    for (int k = 0; k < 12; k++) begin
      fi = $urandom;
      if (k < 4) fi[21:0] = 22'h0;
      if (k == 0) fi[31] = 1'b0;
      if (k == 1) fi = -fi;
      mg = fi[31] ? -fi : fi;
      fo = (mg[21:0] == 22'h0) ? 32'h0 : fi;
      apb(1'b1, OAG_ADDR_FPIN, fi);
      apb(1'b0, OAG_ADDR_FPOUT, 32'h0);
      chk("fpout", fo, rv);
      apb(1'b0, OAG_ADDR_FPNEG, 32'h0);
      chk("fpneg", -fo, rv);
      apb(1'b0, OAG_ADDR_FPSCALE, 32'h0);
      chk("fpscale", 32'(int'(mg[30:22]) - 256), rv);
    end
    $display("test formats done");
    give_verdict();
  end
  initial begin
    #400000;
    fails++;
    give_verdict();
  end
endmodule
